// file: rtl/crf_cfg.svh
/*
 * Address map, reset values and fixed sizes of the core datapath.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH

// ****************************************
// Data space map
// ****************************************
`define CRF_RF_SIZE     16'h0020
`define CRF_IO_BASE     16'h0020
`define CRF_EXT_BASE    16'h0060
`define CRF_EXT_TOP     16'h00FF
`define CRF_IO_STKP_LO  6'h3D
`define CRF_IO_STKP_HI  6'h3E
`define CRF_IO_FLAGS    6'h3F
`define CRF_PTR_X       5'h1A

// ****************************************
// Reset values and vectors
// ****************************************
`define CRF_FLAGS_RST   8'h00
`define CRF_STKP_RST    16'h04FF
`define CRF_RST_VEC     16'h0000
`define CRF_VEC_STRIDE  16'h0001
`define CRF_NIRQ        8

`endif

// file: rtl/crf_core.sv
/*
 * Core datapath: fetch stage, 32 x 8 working registers, status flags,
 * stack pointer, data space decode and interrupt entry.
 * Assumes program memory returns pm_data for pm_addr in the same cycle,
 * and data memory returns dm_rdata in the cycle its read request stands.
 */
`timescale 1ns/1ps
`default_nettype none
`include "crf_cfg.svh"

// Overview of operation
// - Next word is fetched while the current instruction executes.
// - Thirty-two 8-bit working registers with single-cycle access.
// - Two-operand ALU ops read, compute and write back in one cycle.
// - Registers 26..31 form three 16-bit data pointers.
// - Ports: 8 in/8 out, two 8 in/8 out, two 8 in/16 out, 16/16.
// - Working registers occupy data addresses 0x00 to 0x1F.
// - 64 I/O locations, direct or at data addresses 0x20 to 0x5F.
// - Extended I/O 0x60 to 0xFF only via data load/store.
// - Instructions are one or two 16-bit words.
// - Interrupts and calls push the return address to data memory.
// - Lowest pending vector wins.
// - Flags update after every ALU operation except move, swap and load immediate.
// - Status flags are never saved or restored by hardware.
// - Global enable clear blocks every interrupt.
// - Entry clears global enable; interrupt return and set op set it.
// - Bit 6 is the bit copy store for bit store/load ops.
// - Bit 5 holds low-nibble carry.
// - Bit 4 equals negative xor overflow after every ALU-group operation.
// - Bit 3 flags two's complement overflow.
// - Bit 2 flags a negative result.
// - Bit 1 flags a zero result.
// - Bit 0 holds the carry.
// - Stack pointer moves by one per byte, two per address.
module crf_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Program memory
  output logic [15:0]              pm_addr,
  input  wire logic [15:0]         pm_data,
  // Data memory
  output var crf_pkg::crf_dmem_t   dm_req,
  input  wire logic [7:0]          dm_rdata,
  // Interrupts
  input  wire logic [`CRF_NIRQ-1:0] irq_req,
  output logic [`CRF_NIRQ-1:0]     irq_ack,
  // Status
  output var crf_pkg::crf_flags_t  status_flags
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_reg <= 2'b00;
    else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // State
  // ****************************************
  crf_pkg::crf_state_t st_reg, st_next;
  crf_pkg::crf_flags_t status_flags_reg, sf_next, alu_fl;
  crf_pkg::crf_dmem_t  dm_reg, dm_next;
  logic [7:0]  gpr_reg [32];
  logic [15:0] program_counter_reg, pc_next;
  logic [15:0] ir_reg, ir_next, ir_addr_reg, iaddr_next;
  logic        ir_valid_reg, irv_next, hold_reg, hold_next;
  logic [15:0] stack_pointer_reg, stkp_next, ret_addr_reg, ret_next;
  logic [15:0] ld_addr_reg, ldaddr_next;
  logic [4:0]  ld_rd_reg, ldrd_next;
  logic [`CRF_NIRQ-1:0] ack_reg, ack_next;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic in_rf(input logic [15:0] a);
    in_rf = a < `CRF_RF_SIZE;
  endfunction

  function automatic logic io_at(input logic [15:0] a, input logic [5:0] io);
    io_at = a == `CRF_IO_BASE + {10'h000, io};
  endfunction

  function automatic logic [2:0] low_idx(input logic [`CRF_NIRQ-1:0] v);
    low_idx = 3'h0;
    for (int k = `CRF_NIRQ - 1; k >= 0; k--) if (v[k]) low_idx = 3'(k);
  endfunction

  // Result of x+y or x-y, packed as {h, v, c, r[7:0]}
  function automatic logic [10:0] arith(input logic [7:0] x, y,
                                        input logic ci, sub);
    logic [7:0] yy;
    logic [4:0] lo;
    logic [8:0] s;
    yy = sub ? ~y : y;
    lo = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci ^ sub};
    s  = {1'b0, x} + {1'b0, yy} + {8'h00, ci ^ sub};
    arith = {lo[4] ^ sub, (x[7] == yy[7]) && (s[7] != x[7]), s[8] ^ sub, s[7:0]};
  endfunction

  crf_pkg::crf_grp_t grp;
  logic [15:0] ir;
  logic [2:0]  fn, irq_idx;
  logic [4:0]  rd, rr, ptr_idx;
  logic [7:0]  a_op, b_op, ld_val;
  logic [15:0] ptr_val, io_addr, daddr, irq_vec, br_tgt, jmp_tgt;
  logic [`CRF_NIRQ-1:0] irq_grant;
  logic        take_irq, exec, alu_grp, is_push, is_pop, d_st, d_ld, d_ext, bst_bit;

  assign ir      = ir_reg;
  assign grp     = crf_pkg::crf_grp_t'(ir[15:13]);
  assign fn      = ir[12:10];
  assign rd      = ir[9:5];
  assign rr      = ir[4:0];
  assign a_op    = gpr_reg[rd];
  assign b_op    = gpr_reg[rr];
  assign bst_bit = a_op[ir[2:0]];

  // Lowest index is the lowest vector address
  assign irq_grant = irq_req & (~irq_req + 8'h01);
  assign irq_idx   = low_idx(irq_grant);
  assign irq_vec   = `CRF_RST_VEC + 16'(({13'h0000, irq_idx} + 16'h0001) * `CRF_VEC_STRIDE);
  // Sei/return_from_irq_op let one more instruction run before the next entry
  assign take_irq  = st_reg == crf_pkg::ST_RUN && ir_valid_reg && status_flags_reg.i
                     && |irq_req && !hold_reg;
  assign exec      = st_reg == crf_pkg::ST_RUN && ir_valid_reg && !take_irq;
  assign alu_grp   = grp == crf_pkg::GRP_ALU || grp == crf_pkg::GRP_LDI
                     || grp == crf_pkg::GRP_UNARY;

  assign ptr_idx = `CRF_PTR_X + {2'b00, fn[1:0], 1'b0};
  assign ptr_val = {gpr_reg[ptr_idx + 5'h01], gpr_reg[ptr_idx]};
  // Only six I/O address bits fit, so direct I/O never reaches extended I/O
  assign io_addr = `CRF_IO_BASE + {10'h000, ir[10], ir[4:0]};
  assign is_push = grp == crf_pkg::GRP_MISC && fn == 3'h6;
  assign is_pop  = grp == crf_pkg::GRP_MISC && fn == 3'h7;
  assign daddr   = grp == crf_pkg::GRP_PTR ? ptr_val :
                   grp == crf_pkg::GRP_IOX ? (ir[12] ? pm_data : io_addr) :
                   is_pop ? stack_pointer_reg + 16'h0001 : stack_pointer_reg;
  assign d_st    = exec && ((grp == crf_pkg::GRP_PTR && ir[12])
                   || (grp == crf_pkg::GRP_IOX && ir[11]) || is_push);
  assign d_ld    = exec && ((grp == crf_pkg::GRP_PTR && !ir[12])
                   || (grp == crf_pkg::GRP_IOX && !ir[11]) || is_pop);
  assign d_ext   = !(in_rf(daddr) || io_at(daddr, `CRF_IO_FLAGS)
                   || io_at(daddr, `CRF_IO_STKP_LO) || io_at(daddr, `CRF_IO_STKP_HI));
  assign ld_val  = in_rf(ld_addr_reg) ? gpr_reg[ld_addr_reg[4:0]] :
                   io_at(ld_addr_reg, `CRF_IO_FLAGS) ? status_flags_reg :
                   io_at(ld_addr_reg, `CRF_IO_STKP_LO) ? stack_pointer_reg[7:0] :
                   io_at(ld_addr_reg, `CRF_IO_STKP_HI) ? stack_pointer_reg[15:8] : dm_rdata;
  assign br_tgt  = ir_addr_reg + 16'h0001 + {{7{ir[8]}}, ir[8:0]};
  assign jmp_tgt = ir_addr_reg + 16'h0001 + {{4{ir[11]}}, ir[11:0]};

  // ****************************************
  // ALU
  // ****************************************
  logic [1:0]  alu_wen;
  logic [4:0]  alu_adr;
  logic [15:0] alu_res;

  always_comb begin
    logic [10:0] ar;
    logic        upd, wide;
    ar      = 11'h000;
    upd     = 1'b0;
    wide    = 1'b0;
    alu_fl  = status_flags_reg;
    alu_res = {8'h00, a_op};
    alu_wen = 2'b00;
    alu_adr = rd;
    unique case (grp)
      crf_pkg::GRP_ALU: begin
        alu_wen = 2'b01;
        if (!fn[2]) begin
          ar = arith(a_op, b_op, fn[0] & status_flags_reg.c, fn[1]);
          {alu_fl.h, alu_fl.v, alu_fl.c} = ar[10:8];
          alu_res = {8'h00, ar[7:0]};
          upd     = 1'b1;
        end else begin
          unique case (fn[1:0])
            2'h0: alu_res = {8'h00, a_op & b_op};
            2'h1: alu_res = {8'h00, a_op | b_op};
            2'h2: alu_res = {8'h00, a_op ^ b_op};
            2'h3: alu_res = {8'h00, b_op};
          endcase
          upd      = fn[1:0] != 2'h3;
          alu_fl.v = fn[1:0] == 2'h3 ? status_flags_reg.v : 1'b0;
        end
      end
      crf_pkg::GRP_LDI: begin
        alu_wen = 2'b01;
        alu_adr = ir[12:8];
        alu_res = {8'h00, ir[7:0]};
      end
      crf_pkg::GRP_UNARY: begin
        alu_wen = 2'b01;
        upd     = 1'b1;
        unique case (fn)
          3'h0: begin alu_res = {8'h00, ~a_op}; alu_fl.c = 1'b1; alu_fl.v = 1'b0; end
          3'h1: begin
            ar = arith(8'h00, a_op, 1'b0, 1'b1);
            {alu_fl.h, alu_fl.v, alu_fl.c} = ar[10:8];
            alu_res = {8'h00, ar[7:0]};
          end
          3'h2, 3'h3: begin
            ar = arith(a_op, 8'h01, 1'b0, fn[0]);
            alu_fl.v = ar[9];
            alu_res  = {8'h00, ar[7:0]};
          end
          3'h4: begin alu_res = {9'h000, a_op[7:1]}; alu_fl.c = a_op[0]; alu_fl.v = a_op[0]; end
          3'h5: begin
            alu_adr = {rd[4:1], 1'b0};
            alu_res = {gpr_reg[alu_adr + 5'h01], gpr_reg[alu_adr]} + {11'h000, rr};
            alu_wen = 2'b11;
            wide    = 1'b1;
            alu_fl.c = !alu_res[15] && gpr_reg[alu_adr + 5'h01][7];
            alu_fl.v = alu_res[15] && !gpr_reg[alu_adr + 5'h01][7];
          end
          3'h6: begin
            alu_res  = a_op * b_op;
            alu_adr  = 5'h00;
            alu_wen  = 2'b11;
            wide     = 1'b1;
            alu_fl.c = alu_res[15];
          end
          3'h7: begin alu_res = {8'h00, a_op[3:0], a_op[7:4]}; upd = 1'b0; end
        endcase
      end
      crf_pkg::GRP_MISC, crf_pkg::GRP_PTR, crf_pkg::GRP_IOX,
      crf_pkg::GRP_JMP, crf_pkg::GRP_BR: ;
    endcase
    if (upd) begin
      alu_fl.n = wide ? alu_res[15] : alu_res[7];
      alu_fl.z = wide ? alu_res == 16'h0000 : alu_res[7:0] == 8'h00;
    end
    alu_fl.s = alu_fl.n ^ alu_fl.v;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic [1:0]  wen;
  logic [4:0]  wadr;
  logic [15:0] wdat;

  always_comb begin
    logic [7:0] bld_val;
    bld_val          = a_op;
    bld_val[ir[2:0]] = status_flags_reg.t;
    st_next     = st_reg;
    pc_next     = program_counter_reg;
    ir_next     = ir_reg;
    iaddr_next  = ir_addr_reg;
    irv_next    = ir_valid_reg;
    sf_next     = status_flags_reg;
    stkp_next   = stack_pointer_reg;
    hold_next   = hold_reg;
    dm_next     = '0;
    ack_next    = '0;
    ldaddr_next = ld_addr_reg;
    ldrd_next   = ld_rd_reg;
    ret_next    = ret_addr_reg;
    wen         = 2'b00;
    wadr        = rd;
    wdat        = {8'h00, bld_val};
    unique case (st_reg)
      crf_pkg::ST_RUN: begin
        pc_next    = program_counter_reg + 16'h0001;
        ir_next    = pm_data;
        iaddr_next = program_counter_reg;
        irv_next   = 1'b1;
        if (take_irq) begin
          // Flags other than global enable stay as they are: handlers save them if needed
          ret_next   = ir_addr_reg;
          pc_next    = irq_vec;
          irv_next   = 1'b0;
          sf_next.i  = 1'b0;
          ack_next   = irq_grant;
          dm_next    = '{stack_pointer_reg, ir_addr_reg[7:0], 1'b1, 1'b0};
          stkp_next  = stack_pointer_reg - 16'h0001;
          st_next    = crf_pkg::ST_PUSH2;
        end else if (ir_valid_reg) begin
          hold_next = 1'b0;
          unique case (grp)
            crf_pkg::GRP_ALU, crf_pkg::GRP_LDI, crf_pkg::GRP_UNARY: begin
              wen     = alu_wen;
              wadr    = alu_adr;
              wdat    = alu_res;
              sf_next = alu_fl;
            end
            crf_pkg::GRP_MISC: begin
              unique case (fn)
                3'h0: sf_next.t = bst_bit;
                3'h1: wen = 2'b01;
                3'h2: begin sf_next.i = 1'b1; hold_next = 1'b1; end
                3'h3: sf_next.i = 1'b0;
                3'h4, 3'h5: begin
                  dm_next   = '{stack_pointer_reg + 16'h0001, 8'h00, 1'b0, 1'b1};
                  stkp_next = stack_pointer_reg + 16'h0001;
                  irv_next  = 1'b0;
                  st_next   = crf_pkg::ST_POP_HI;
                  if (fn[0]) begin sf_next.i = 1'b1; hold_next = 1'b1; end
                end
                3'h6: stkp_next = stack_pointer_reg - 16'h0001;
                3'h7: stkp_next = stack_pointer_reg + 16'h0001;
              endcase
            end
            crf_pkg::GRP_PTR: ;
            crf_pkg::GRP_IOX: if (ir[12]) irv_next = 1'b0;
            crf_pkg::GRP_JMP: begin
              pc_next  = jmp_tgt;
              irv_next = 1'b0;
              if (ir[12]) begin
                ret_next  = ir_addr_reg + 16'h0001;
                dm_next   = '{stack_pointer_reg, ret_next[7:0], 1'b1, 1'b0};
                stkp_next = stack_pointer_reg - 16'h0001;
                st_next   = crf_pkg::ST_PUSH2;
              end
            end
            crf_pkg::GRP_BR: if (status_flags_reg[fn] == ir[9]) begin
              pc_next  = br_tgt;
              irv_next = 1'b0;
            end
          endcase
          if (d_st) begin
            if (in_rf(daddr)) begin
              wen  = 2'b01;
              wadr = daddr[4:0];
              wdat = {8'h00, a_op};
            end else if (io_at(daddr, `CRF_IO_FLAGS))
              sf_next = a_op;
            else if (io_at(daddr, `CRF_IO_STKP_LO))
              stkp_next[7:0] = a_op;
            else if (io_at(daddr, `CRF_IO_STKP_HI))
              stkp_next[15:8] = a_op;
            else
              dm_next = '{daddr, a_op, 1'b1, 1'b0};
          end
          if (d_ld) begin
            ldaddr_next = daddr;
            ldrd_next   = rd;
            dm_next     = '{daddr, 8'h00, 1'b0, d_ext};
            st_next     = crf_pkg::ST_LOAD;
          end
        end
      end
      crf_pkg::ST_LOAD: begin
        wen     = 2'b01;
        wadr    = ld_rd_reg;
        wdat    = {8'h00, ld_val};
        st_next = crf_pkg::ST_RUN;
      end
      crf_pkg::ST_PUSH2: begin
        dm_next   = '{stack_pointer_reg, ret_addr_reg[15:8], 1'b1, 1'b0};
        stkp_next = stack_pointer_reg - 16'h0001;
        st_next   = crf_pkg::ST_RUN;
      end
      crf_pkg::ST_POP_HI: begin
        ret_next[15:8] = dm_rdata;
        dm_next   = '{stack_pointer_reg + 16'h0001, 8'h00, 1'b0, 1'b1};
        stkp_next = stack_pointer_reg + 16'h0001;
        st_next   = crf_pkg::ST_POP_LO;
      end
      crf_pkg::ST_POP_LO: begin
        pc_next  = {ret_addr_reg[15:8], dm_rdata};
        irv_next = 1'b0;
        st_next  = crf_pkg::ST_RUN;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpr_reg <= '{default: 8'h00};
    end else begin
      if (wen[0]) gpr_reg[wadr] <= wdat[7:0];
      if (wen[1]) gpr_reg[wadr + 5'h01] <= wdat[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg              <= crf_pkg::ST_RUN;
      status_flags_reg    <= `CRF_FLAGS_RST;
      program_counter_reg <= `CRF_RST_VEC;
      ir_reg              <= 16'h0000;
      ir_addr_reg         <= 16'h0000;
      ir_valid_reg        <= 1'b0;
      hold_reg            <= 1'b0;
      stack_pointer_reg   <= `CRF_STKP_RST;
      ret_addr_reg        <= 16'h0000;
      ld_addr_reg         <= 16'h0000;
      ld_rd_reg           <= 5'h00;
      dm_reg              <= '0;
      ack_reg             <= '0;
    end else begin
      st_reg              <= st_next;
      status_flags_reg    <= sf_next;
      program_counter_reg <= pc_next;
      ir_reg              <= ir_next;
      ir_addr_reg         <= iaddr_next;
      ir_valid_reg        <= irv_next;
      hold_reg            <= hold_next;
      stack_pointer_reg   <= stkp_next;
      ret_addr_reg        <= ret_next;
      ld_addr_reg         <= ldaddr_next;
      ld_rd_reg           <= ldrd_next;
      dm_reg              <= dm_next;
      ack_reg             <= ack_next;
    end
  end

  assign pm_addr      = program_counter_reg;
  assign dm_req       = dm_reg;
  assign irq_ack      = ack_reg;
  assign status_flags = status_flags_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence push_pair_s;
    dm_reg.we ##1 dm_reg.we;
  endsequence

  reset_flags_a: assert property (@(posedge clk) $rose(rst_n) |-> status_flags_reg == 8'h00)
    else $error("status flags not clear after reset");
  fetch_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg == crf_pkg::ST_RUN && !ir_valid_reg
    |=> ir_valid_reg && program_counter_reg == $past(program_counter_reg) + 16'h0001)
    else $error("fetch did not advance");
  sign_xor_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && alu_grp |=> status_flags_reg.s == (status_flags_reg.n ^ status_flags_reg.v))
    else $error("sign flag differs from n xor v");
  gie_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    |irq_ack |-> $past(status_flags_reg.i))
    else $error("interrupt taken with global enable clear");
  gie_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    take_irq |=> !status_flags_reg.i && |irq_ack)
    else $error("global enable not cleared at entry");
  irq_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
    |irq_ack |-> $onehot(irq_ack) && ((irq_ack - 8'h01) & $past(irq_req)) == 8'h00)
    else $error("higher priority request skipped");
  irq_push_a: assert property (@(posedge clk) disable iff (!rst_n)
    take_irq |=> push_pair_s)
    else $error("return address not pushed");
  stack_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    take_irq |=> ##1 stack_pointer_reg == $past(stack_pointer_reg, 2) - 16'h0002)
    else $error("stack pointer not lowered by two");
  bit_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec && grp == crf_pkg::GRP_MISC && fn == 3'h0 |=> status_flags_reg.t == $past(bst_bit))
    else $error("bit store value lost");

endmodule
`default_nettype wire

// file: rtl/crf_pkg.sv
/*
 * Types shared by the core datapath: status flags, data bus request,
 * instruction groups and sequencer states.
 * Assumes nothing of its surroundings.
 */
package crf_pkg;

  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } crf_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } crf_dmem_t;

  typedef enum logic [2:0] {
    GRP_ALU, GRP_LDI, GRP_UNARY, GRP_MISC, GRP_PTR, GRP_IOX, GRP_JMP, GRP_BR
  } crf_grp_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_LOAD, ST_PUSH2, ST_POP_HI, ST_POP_LO
  } crf_state_t;

endpackage

// file: verif/cpu_core_regfile_status_bench.sv
/*
 * Self-checking bench: ALU flags via status reads and stores, then
 * interrupt priority and stack pushes. Assumes crf_core and crf_mem_model.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_regfile_status_bench;
  logic               clk, arst_n;
  logic [15:0]        pm_addr, pm_data;
  crf_pkg::crf_dmem_t dm_req;
  logic [7:0]         dm_rdata, irq_req, irq_ack;
  crf_pkg::crf_flags_t status_flags;
  int                 error_cnt, num_checks, cyc, nack, nstk, npop, e;
  int                 exp_q[$];
  crf_core DUT (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_req(dm_req), .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
    .status_flags(status_flags));
  crf_mem_model mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************
  // Checks and reference model
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic int alu(input int fn, input int a, input int b, inout int fl);
    int r, c, h, v, n, ci;
    c = fl & 1;
    h = fl >> 5 & 1;
    v = 0;
    ci = (fn == 1 || fn == 3) ? c : 0;
    case (fn)
      0, 1: begin
        r = a + b + ci;
        h = (a & 15) + (b & 15) + ci > 15;
        c = r > 255;
        v = ((a ^ r) & (b ^ r) & 128) != 0;
      end
      2, 3: begin
        r = a - b - ci;
        h = (a & 15) < (b & 15) + ci;
        c = a < b + ci;
        v = ((a ^ b) & (a ^ r) & 128) != 0;
      end
      4: r = a & b;
      5: r = a | b;
      6: r = a ^ b;
      default: r = b;
    endcase
    r &= 255;
    n = r >> 7;
    if (fn != 7) fl = fl & 8'hC0 | h << 5 | (n ^ v) << 4 | v << 3 | n << 2 | (r == 0) << 1 | c;
    return r;
  endfunction
  // ****************************************
  // Monitors, request release, timeout
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (arst_n && dm_req.we === 1'b1) begin
      if (dm_req.addr >= 16'h0100) begin
        chk("stack addr", nstk[0] ? 16'h04FE : 16'h04FF, dm_req.addr);
        nstk++;
      end else begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
        chk("store addr", 16'(e >> 8), dm_req.addr);
        chk("store data", 16'(e & 255), 16'(dm_req.wdata));
      end
    end
    if (arst_n && dm_req.re === 1'b1) begin
      chk("pop addr", npop[0] ? 16'h04FF : 16'h04FE, dm_req.addr);
      npop++;
    end
    if (arst_n && irq_ack !== 8'h00) begin
      chk("stores before entry", 16'h0000, 16'(exp_q.size()));
      chk("irq grant", nack == 0 ? 16'h0008 : 16'h0020, 16'(irq_ack));
      chk("gate after entry", 16'h0000, 16'(status_flags.i));
      nack++;
    end
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Acknowledge is unknown until reset reaches it, so leave requests alone until then
  always @(negedge clk) if (arst_n === 1'b1) irq_req <= irq_req & ~irq_ack;
  // ****************************************
  // Program build and main sequence
  // ****************************************
  initial begin
    int pc, r, fn, fl, a, b;
    arst_n = 1'b0;
    irq_req = 8'h28;
    void'($urandom(32'h52f2a4e3));
    for (pc = 0; pc < 256; pc++) mem.pm[pc] = 16'hCFFF;
    mem.pm[0] = 16'hC00F;
    for (pc = 1; pc <= 8; pc++) mem.pm[pc] = 16'h7400;
    pc = 16;
    fl = 0;
    for (r = 0; r < 16; r++) begin
      fn = r % 8;
      a = $urandom & 255;
      b = $urandom & 255;
      mem.pm[pc] = {3'b001, 5'd16, 8'(a)};
      mem.pm[pc+1] = {3'b001, 5'd17, 8'(b)};
      mem.pm[pc+2] = {3'b000, 3'(fn), 5'd16, 5'd17};
      mem.pm[pc+3] = {6'b101001, 5'd18, 5'h1F};
      mem.pm[pc+4] = {6'b101110, 5'd16, 5'h00};
      mem.pm[pc+5] = 16'h0060;
      mem.pm[pc+6] = {6'b101110, 5'd18, 5'h00};
      mem.pm[pc+7] = 16'h0061;
      pc += 8;
      a = alu(fn, a, b, fl);
      exp_q.push_back(32'h6000 | a);
      exp_q.push_back(32'h6100 | fl);
    end
    // Bit 0 of the last result goes through the copy store into the saved flags
    mem.pm[pc] = 16'h6200;
    mem.pm[pc+1] = 16'h6640;
    mem.pm[pc+2] = 16'hBA40;
    mem.pm[pc+3] = 16'h0062;
    exp_q.push_back(32'h6200 | fl & 254 | a & 1);
    mem.pm[pc+4] = 16'h6800;
    repeat (3) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk("flags at reset", 16'h0000, 16'(status_flags));
    chk("first fetch", 16'h0000, pm_addr);
    while (exp_q.size() > 0) @(negedge clk);
    $display("ALU and status test done");
    while (nack < 2) @(negedge clk);
    repeat (8) @(negedge clk);
    chk("stack pushes", 16'h0004, 16'(nstk));
    chk("stack pops", 16'h0004, 16'(npop));
    $display("Interrupt test done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: verif/crf_mem_model.sv
/*
 * Program and data memory model standing beside the core.
 * Assumes the bench loads pm by hierarchy and that one clock serves all.
 */
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model (
  // Clock
  input  wire logic              clk,
  // Program memory
  input  wire logic [15:0]       pm_addr,
  output logic [15:0]            pm_data,
  // Data memory
  input  var crf_pkg::crf_dmem_t dm_req,
  output logic [7:0]             dm_rdata
);
  logic [15:0] pm [0:255];
  logic [7:0]  dm [0:1279];
  logic [7:0]  last = 8'h00;
  // Same-cycle word so a fetch can overlap execution
  assign pm_data = pm[pm_addr[7:0]];
  // Idle bus shows the inverse of the last byte, never a stale copy
  assign dm_rdata = dm_req.re ? dm[dm_req.addr] : ~last;
  always @(posedge clk) begin
    if (dm_req.re) last <= dm[dm_req.addr];
    if (dm_req.we) dm[dm_req.addr] <= dm_req.wdata;
  end
endmodule
`default_nettype wire
